// ### core/swm_pkg.sv
// swm_pkg: constants and types for the status word transfer and product unit
// assumes an upstream decoder supplies decoded fields and register operands
package swm_pkg;
   localparam int XLEN = 32;
   localparam int IMM_W = 8;
   localparam int ROT_W = 4;
   localparam int FIELD_W = 4;
   localparam int MODE_W = 5;
   localparam int BANK_IDX_W = 4;
   localparam int BANK_DEPTH = 16;
   localparam int FLD_CTL = 0;
   localparam int FLD_EXT = 1;
   localparam int FLD_STS = 2;
   localparam int FLD_FLG = 3;
   localparam logic [31:0] IMPL_MASK = 32'hF00000DF;
   localparam logic [31:0] FLAG_NIB_MASK = 32'hF0000000;
   localparam logic [31:0] RESET_STATUS = 32'h000000D3;
   localparam logic [31:0] ZERO_WORD = 32'h00000000;
   localparam logic [4:0] MODE_UNPRIV = 5'h10;
   localparam logic [4:0] MODE_SYSTEM = 5'h1F;
   localparam logic [3:0] MASK_ALL = 4'h9;
   localparam logic [3:0] MASK_FLG = 4'h8;
   localparam logic [3:0] MASK_CTL = 4'h1;
   localparam logic [1:0] LEGACY_ALL = 2'h0;
   localparam logic [1:0] LEGACY_FLG = 2'h1;
   localparam logic [1:0] LEGACY_CTL = 2'h2;
   localparam logic [1:0] SLOW_LAST = 2'h2;
   typedef enum logic [1:0] {
      SWM_OP_READ = 2'b00,
      SWM_OP_WRITE = 2'b01,
      SWM_OP_PRODUCT = 2'b10,
      SWM_OP_ACCUM = 2'b11
   } swm_op_e;
   typedef enum logic {
      SWM_ST_IDLE = 1'b0,
      SWM_ST_HOLD = 1'b1
   } swm_state_e;
endpackage : swm_pkg

// ### core/swm_product.sv
// swm_product: combinational low-half multiply and optional accumulate
// assumes the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module swm_product (
   input wire logic [31:0] factor_a,
   input wire logic [31:0] factor_b,
   input wire logic [31:0] addend,
   input wire logic accumulate,
   output logic [31:0] low_result
);
   logic [31:0] prod_low;
   // low half is identical for signed and unsigned, one datapath
   assign prod_low = 32'(factor_a * factor_b);
   // addend only joins for the accumulate form
   assign low_result = accumulate ? 32'(prod_low + addend) : prod_low;
endmodule : swm_product
`default_nettype wire

// ### core/swm_unit.sv
// swm_unit: status word transfer and 32-bit product execution unit
// assumes decoded instruction fields arrive on the core clock with op_valid
`timescale 1ns/1ps
`default_nettype none
module swm_unit (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic op_valid,
   input wire swm_pkg::swm_op_e op_kind,
   input wire logic cond_pass,
   input wire logic use_saved,
   input wire logic [3:0] field_mask,
   input wire logic legacy_form,
   input wire logic [1:0] legacy_kind,
   input wire logic imm_sel,
   input wire logic [7:0] imm_value,
   input wire logic [3:0] imm_rotate,
   input wire logic [31:0] src_value,
   input wire logic [31:0] multiplicand_reg,
   input wire logic [31:0] multiplier_reg,
   input wire logic [31:0] addend_reg,
   output logic op_ready,
   output logic op_done,
   output logic result_valid,
   output logic [31:0] result_data,
   output logic [31:0] current_status_word,
   output logic [31:0] saved_status_word
);
   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   swm_pkg::swm_state_e state_reg, state_next;
   logic [1:0] cnt_reg, cnt_next;
   logic ready_reg, ready_next;
   logic done_reg, done_next;
   logic res_valid_reg, res_valid_next;
   logic [31:0] res_data_reg, res_data_next;
   logic [31:0] cur_reg, cur_next;
   logic [31:0] saved_view_reg, saved_view_next;
   logic [31:0] pend_data_reg, pend_data_next;
   logic [31:0] pend_mask_reg, pend_mask_next;
   logic [31:0] bank_reg [swm_pkg::BANK_DEPTH];
   logic [31:0] bank_next [swm_pkg::BANK_DEPTH];

   logic taken;
   logic exec;
   logic [4:0] mode;
   logic is_unpriv;
   logic saved_ok;
   logic [3:0] bank_idx;
   logic [3:0] mask_req;
   logic [31:0] wdata;
   logic [31:0] byte_bits;
   logic [31:0] wmask;
   logic slow_write;
   logic [31:0] imm_word;
   logic [31:0] prod_out;
   logic [4:0] mode_nx;
   logic saved_ok_nx;

   assign taken = op_valid && ready_reg;
   assign exec = taken && cond_pass;
   assign mode = cur_reg[swm_pkg::MODE_W-1:0];
   assign is_unpriv = (mode == swm_pkg::MODE_UNPRIV);
   // unprivileged and system modes own no saved word
   assign saved_ok = !is_unpriv && (mode != swm_pkg::MODE_SYSTEM);
   assign bank_idx = mode[swm_pkg::BANK_IDX_W-1:0];

   // ------------------------------------------------------------
   // operand and mask decode
   // ------------------------------------------------------------
   function automatic logic [3:0] legacy_map(input logic [1:0] kind);
      logic [3:0] m;
      m = swm_pkg::MASK_ALL;
      case (kind)
         swm_pkg::LEGACY_FLG: m = swm_pkg::MASK_FLG;
         swm_pkg::LEGACY_CTL: m = swm_pkg::MASK_CTL;
         default: m = swm_pkg::MASK_ALL;
      endcase
      return m;
   endfunction : legacy_map

   function automatic logic [31:0] rot_imm(input logic [7:0] v, input logic [3:0] r);
      logic [63:0] dbl;
      logic [63:0] sh;
      dbl = {24'h000000, v, 24'h000000, v};
      sh = dbl >> {r, 1'b0};
      return sh[31:0];
   endfunction : rot_imm

   always_comb begin
      imm_word = rot_imm(imm_value, imm_rotate);
      mask_req = legacy_form ? legacy_map(legacy_kind) : field_mask;
      if (imm_sel) begin
         mask_req = swm_pkg::MASK_FLG;
      end
      wdata = imm_sel ? imm_word : src_value;
      for (int i = 0; i < swm_pkg::FIELD_W; i++) begin
         byte_bits[8*i +: 8] = {8{mask_req[i]}};
      end
      // reserved bits, flag byte 27:24 included, are never stored
      wmask = byte_bits & swm_pkg::IMPL_MASK;
      if (is_unpriv && !use_saved) begin
         wmask = wmask & swm_pkg::FLAG_NIB_MASK;
      end
      // cost depends on the request, not on protection
      slow_write = !use_saved && (mask_req != swm_pkg::MASK_FLG);
   end

   swm_product u_product (
      .factor_a(multiplicand_reg),
      .factor_b(multiplier_reg),
      .addend(addend_reg),
      .accumulate(op_kind == swm_pkg::SWM_OP_ACCUM),
      .low_result(prod_out)
   );

   // ------------------------------------------------------------
   // sequencing and results
   // ------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      ready_next = ready_reg;
      done_next = 1'b0;
      res_valid_next = 1'b0;
      res_data_next = res_data_reg;
      cur_next = cur_reg;
      pend_data_next = pend_data_reg;
      pend_mask_next = pend_mask_reg;
      bank_next = bank_reg;
      case (state_reg)
         swm_pkg::SWM_ST_IDLE: begin
            if (taken) begin
               done_next = 1'b1;
            end
            if (exec) begin
               case (op_kind)
                  swm_pkg::SWM_OP_READ: begin
                     res_valid_next = 1'b1;
                     if (!use_saved) begin
                        res_data_next = cur_reg;
                     end else if (saved_ok) begin
                        res_data_next = bank_reg[bank_idx];
                     end else begin
                        res_data_next = swm_pkg::ZERO_WORD;
                     end
                  end
                  swm_pkg::SWM_OP_WRITE: begin
                     if (use_saved) begin
                        if (saved_ok) begin
                           bank_next[bank_idx] = (bank_reg[bank_idx] & ~wmask)
                              | (wdata & wmask);
                        end
                     end else if (slow_write) begin
                        // commit waits so the mode change lands at the end
                        done_next = 1'b0;
                        ready_next = 1'b0;
                        cnt_next = 2'h1;
                        pend_data_next = wdata;
                        pend_mask_next = wmask;
                        state_next = swm_pkg::SWM_ST_HOLD;
                     end else begin
                        cur_next = (cur_reg & ~wmask) | (wdata & wmask);
                     end
                  end
                  default: begin
                     res_valid_next = 1'b1;
                     res_data_next = prod_out;
                  end
               endcase
            end
         end
         swm_pkg::SWM_ST_HOLD: begin
            cnt_next = 2'(cnt_reg + 2'h1);
            if (cnt_reg == swm_pkg::SLOW_LAST) begin
               cur_next = (cur_reg & ~pend_mask_reg) | (pend_data_reg & pend_mask_reg);
               done_next = 1'b1;
               ready_next = 1'b1;
               cnt_next = 2'h0;
               state_next = swm_pkg::SWM_ST_IDLE;
            end
         end
         default: begin
            state_next = swm_pkg::SWM_ST_IDLE;
            ready_next = 1'b1;
         end
      endcase
      // view follows the mode that this same edge installs
      mode_nx = cur_next[swm_pkg::MODE_W-1:0];
      saved_ok_nx = (mode_nx != swm_pkg::MODE_UNPRIV) && (mode_nx != swm_pkg::MODE_SYSTEM);
      saved_view_next = saved_ok_nx ? bank_next[mode_nx[swm_pkg::BANK_IDX_W-1:0]]
         : swm_pkg::ZERO_WORD;
   end

   always_ff @(posedge clk_sys) begin
      if (rst) begin
         state_reg <= swm_pkg::SWM_ST_IDLE;
         cnt_reg <= 2'h0;
         ready_reg <= 1'b1;
         done_reg <= 1'b0;
         res_valid_reg <= 1'b0;
         res_data_reg <= swm_pkg::ZERO_WORD;
         cur_reg <= swm_pkg::RESET_STATUS;
         saved_view_reg <= swm_pkg::ZERO_WORD;
         pend_data_reg <= swm_pkg::ZERO_WORD;
         pend_mask_reg <= swm_pkg::ZERO_WORD;
         for (int i = 0; i < swm_pkg::BANK_DEPTH; i++) begin
            bank_reg[i] <= swm_pkg::ZERO_WORD;
         end
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         ready_reg <= ready_next;
         done_reg <= done_next;
         res_valid_reg <= res_valid_next;
         res_data_reg <= res_data_next;
         cur_reg <= cur_next;
         saved_view_reg <= saved_view_next;
         pend_data_reg <= pend_data_next;
         pend_mask_reg <= pend_mask_next;
         for (int i = 0; i < swm_pkg::BANK_DEPTH; i++) begin
            bank_reg[i] <= bank_next[i];
         end
      end
   end

   assign op_ready = ready_reg;
   assign op_done = done_reg;
   assign result_valid = res_valid_reg;
   assign result_data = res_data_reg;
   assign current_status_word = cur_reg;
   assign saved_status_word = saved_view_reg;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   logic take_read;
   logic take_slow;
   logic take_fast_wr;
   logic take_prod;
   assign take_read = exec && (op_kind == swm_pkg::SWM_OP_READ);
   assign take_slow = exec && (op_kind == swm_pkg::SWM_OP_WRITE) && slow_write;
   assign take_fast_wr = exec && (op_kind == swm_pkg::SWM_OP_WRITE) && !slow_write;
   assign take_prod = exec && (op_kind == swm_pkg::SWM_OP_PRODUCT);

   sequence s_stall_two;
      !op_ready && !op_done ##1 !op_ready && !op_done;
   endsequence
   sequence s_finish;
      op_done && op_ready;
   endsequence

   a_read_one_cycle: assert property (take_read |=> result_valid && op_done)
      else $error("status read did not finish in one cycle");
   a_slow_write_three: assert property (take_slow |=> s_stall_two ##1 s_finish)
      else $error("slow status write not three cycles");
   a_fast_write_one: assert property (take_fast_wr |=> op_done && op_ready)
      else $error("fast status write not one cycle");
   a_reserved_zero: assert property ((current_status_word & ~swm_pkg::IMPL_MASK) == 32'h0)
      else $error("reserved status bits not zero");
   a_unpriv_guard: assert property ((mode == swm_pkg::MODE_UNPRIV) |=>
      $stable(current_status_word[27:0]))
      else $error("unprivileged write changed control bits");
   a_cond_false: assert property (taken && !cond_pass |=>
      op_done && !result_valid && $stable(current_status_word))
      else $error("failed condition had an effect");
   a_product_low: assert property (take_prod |=>
      result_data == 32'($past(multiplicand_reg) * $past(multiplier_reg)))
      else $error("product result wrong");
   a_accum_sum: assert property (exec && op_kind == swm_pkg::SWM_OP_ACCUM |=>
      result_data == 32'($past(multiplicand_reg) * $past(multiplier_reg)
      + $past(addend_reg)))
      else $error("accumulate result wrong");
   a_imm_flags: assert property (take_fast_wr && imm_sel |=>
      current_status_word[27:0] == $past(current_status_word[27:0]))
      else $error("immediate write touched non-flag bits");
   a_flag_value: assert property (take_fast_wr && !use_saved |=>
      current_status_word[31:28] == $past(wdata[31:28]))
      else $error("flag write did not land");
   a_ctl_kept_fast: assert property (take_fast_wr && !use_saved |=>
      current_status_word[7:0] == $past(current_status_word[7:0]))
      else $error("flag-only write touched control byte");
   a_flags_kept_slow: assert property (take_slow && !mask_req[swm_pkg::FLD_FLG] |=>
      ##2 current_status_word[31:24] == $past(current_status_word[31:24], 3))
      else $error("unselected flag byte changed");
   a_ctl_lands_slow: assert property (take_slow && mask_req[swm_pkg::FLD_CTL]
      && !is_unpriv |=> ##2
      current_status_word[7:0] == ($past(wdata[7:0], 3) & swm_pkg::IMPL_MASK[7:0]))
      else $error("privileged control write did not land");
   a_busy_not_ready: assert property ((state_reg == swm_pkg::SWM_ST_HOLD) |->
      !op_ready)
      else $error("unit ready while a slow write is pending");
   a_cur_read_full: assert property (take_read && !use_saved |=>
      result_data == $past(current_status_word))
      else $error("current word read not full width");
   a_saved_read: assert property (take_read && use_saved && saved_ok |=>
      result_data == $past(saved_status_word))
      else $error("saved word read wrong");
   a_no_saved_word: assert property (!saved_ok |->
      saved_status_word == swm_pkg::ZERO_WORD)
      else $error("saved word shown in a mode without one");
endmodule : swm_unit
`default_nettype wire

// ### dv/status_word_transfer_and_multiply_tb.sv
// status_word_transfer_and_multiply_tb: self-checking bench for swm_unit
// assumes swm_pkg is compiled first; the bench keeps its own status word model
`timescale 1ns/1ps
`default_nettype none
module status_word_transfer_and_multiply_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic op_valid = 1'b0;
   swm_pkg::swm_op_e op_kind = swm_pkg::SWM_OP_READ;
   logic cond_pass = 1'b0;
   logic use_saved = 1'b0;
   logic [3:0] field_mask = 4'h0;
   logic legacy_form = 1'b0;
   logic [1:0] legacy_kind = 2'h0;
   logic imm_sel = 1'b0;
   logic [7:0] imm_value = 8'h00;
   logic [3:0] imm_rotate = 4'h0;
   logic [31:0] src_value = 32'h00000000;
   logic [31:0] multiplicand_reg = 32'h00000000;
   logic [31:0] multiplier_reg = 32'h00000000;
   logic [31:0] addend_reg = 32'h00000000;
   logic op_ready;
   logic op_done;
   logic result_valid;
   logic [31:0] result_data;
   logic [31:0] current_status_word;
   logic [31:0] saved_status_word;
   logic [31:0] m_cur;
   logic [31:0] m_data;
   logic [31:0] m_bank [16];
   logic [4:0] pm [6] = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1B, 5'h1F};
   integer seed = 78231;
   integer failures = 0;
   integer samples_checked = 0;

   initial begin
      forever #2.5 clk_sys = ~clk_sys;
   end

   swm_unit swm_unit_inst (.clk_sys(clk_sys), .rst(rst), .op_valid(op_valid),
      .op_kind(op_kind), .cond_pass(cond_pass), .use_saved(use_saved),
      .field_mask(field_mask), .legacy_form(legacy_form), .legacy_kind(legacy_kind),
      .imm_sel(imm_sel), .imm_value(imm_value), .imm_rotate(imm_rotate),
      .src_value(src_value), .multiplicand_reg(multiplicand_reg),
      .multiplier_reg(multiplier_reg), .addend_reg(addend_reg), .op_ready(op_ready),
      .op_done(op_done), .result_valid(result_valid), .result_data(result_data),
      .current_status_word(current_status_word), .saved_status_word(saved_status_word));

   // ----------------------------------------
   // reference model helpers
   // ----------------------------------------
   function automatic logic [31:0] rotr(input logic [7:0] v, input logic [3:0] r);
      logic [63:0] d;
      d = {24'h000000, v, 24'h000000, v} >> (2 * r);
      return d[31:0];
   endfunction : rotr

   // no saved word exists in unprivileged or system mode
   function automatic logic [31:0] saved_view();
      if (m_cur[4:0] == swm_pkg::MODE_UNPRIV || m_cur[4:0] == swm_pkg::MODE_SYSTEM)
         return 32'h00000000;
      return m_bank[m_cur[3:0]];
   endfunction : saved_view

   task automatic check_val(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check_val

   task automatic give_verdict();
      $display("failures %0d samples_checked %0d", failures, samples_checked);
      if (failures == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : give_verdict

   // ----------------------------------------
   // one instruction, issued at posedge + 1
   // ----------------------------------------
   task automatic run_op();
      logic [3:0] eff;
      logic [31:0] wv;
      logic [31:0] bm;
      logic [3:0] bi;
      logic ev;
      int lat;
      int n;
      eff = imm_sel ? swm_pkg::MASK_FLG : !legacy_form ? field_mask :
         (legacy_kind == swm_pkg::LEGACY_FLG) ? swm_pkg::MASK_FLG :
         (legacy_kind == swm_pkg::LEGACY_CTL) ? swm_pkg::MASK_CTL : swm_pkg::MASK_ALL;
      wv = imm_sel ? rotr(imm_value, imm_rotate) : src_value;
      bm = {{8{eff[3]}}, {8{eff[2]}}, {8{eff[1]}}, {8{eff[0]}}} & swm_pkg::IMPL_MASK;
      if (m_cur[4:0] == swm_pkg::MODE_UNPRIV) bm = bm & swm_pkg::FLAG_NIB_MASK;
      ev = cond_pass && op_kind != swm_pkg::SWM_OP_WRITE;
      lat = (op_kind == swm_pkg::SWM_OP_WRITE && !use_saved && eff != swm_pkg::MASK_FLG) ? 3 : 1;
      if (!cond_pass) lat = 1;
      bi = m_cur[3:0];
      if (cond_pass) begin
         case (op_kind)
            swm_pkg::SWM_OP_READ: m_data = use_saved ? saved_view() : m_cur;
            swm_pkg::SWM_OP_PRODUCT: m_data = multiplicand_reg * multiplier_reg;
            swm_pkg::SWM_OP_ACCUM: m_data = multiplicand_reg * multiplier_reg + addend_reg;
            default: begin
               if (!use_saved) m_cur = (m_cur & ~bm) | (wv & bm);
               else if (m_cur[4:0] != swm_pkg::MODE_UNPRIV &&
                  m_cur[4:0] != swm_pkg::MODE_SYSTEM)
                  m_bank[bi] = (m_bank[bi] & ~bm) | (wv & bm);
            end
         endcase
      end
      check_val(op_ready, 1'b1);
      // valid stays up between ops; the unit ignores it while busy
      op_valid = 1'b1;
      @(posedge clk_sys);
      #1 n = 1;
      while (op_done !== 1'b1 && n < 8) begin
         if (lat == 3) check_val(op_ready, 1'b0);
         @(posedge clk_sys);
         #1 n++;
      end
      if (n >= 8) begin
         failures++;
         give_verdict();
      end
      check_val(n, lat);
      check_val(result_valid, ev);
      check_val(result_data, m_data);
      check_val(current_status_word, m_cur);
      check_val(saved_status_word, saved_view());
   endtask : run_op

   task automatic rand_op(input logic [4:0] md);
      logic [31:0] r;
      r = $random(seed);
      op_kind = swm_pkg::swm_op_e'(r[1:0]);
      cond_pass = r[3:2] != 2'h0;
      // no saved word may be named in unprivileged or system mode
      use_saved = r[4] && m_cur[4:0] != swm_pkg::MODE_UNPRIV
         && m_cur[4:0] != swm_pkg::MODE_SYSTEM;
      field_mask = r[8:5];
      legacy_form = r[9];
      legacy_kind = r[11:10];
      imm_sel = r[14:12] == 3'h0;
      imm_value = r[22:15];
      imm_rotate = r[26:23];
      r = $random(seed);
      src_value = {r[31:5], md};
      multiplicand_reg = $random(seed);
      multiplier_reg = $random(seed);
      addend_reg = $random(seed);
   endtask : rand_op

   // mode change by read-modify-write of the current word
   task automatic ctl_write(input logic [4:0] md);
      rand_op(md);
      op_kind = swm_pkg::SWM_OP_READ;
      cond_pass = 1'b1;
      use_saved = 1'b0;
      legacy_form = 1'b0;
      imm_sel = 1'b0;
      field_mask = swm_pkg::MASK_CTL;
      run_op();
      op_kind = swm_pkg::SWM_OP_WRITE;
      src_value = {result_data[31:5], md};
      run_op();
   endtask : ctl_write

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      logic [31:0] r;
      repeat (8) @(posedge clk_sys);
      #1 rst = 1'b0;
      m_cur = swm_pkg::RESET_STATUS;
      m_data = 32'h00000000;
      foreach (m_bank[k]) m_bank[k] = 32'h00000000;
      check_val(current_status_word, m_cur);
      check_val(saved_status_word, 32'h00000000);
      check_val(result_valid, 1'b0);
      rand_op(5'h13);
      op_kind = swm_pkg::SWM_OP_PRODUCT;
      cond_pass = 1'b1;
      multiplicand_reg = 32'hFFFFFFF6;
      multiplier_reg = 32'h00000014;
      run_op();
      for (int i = 0; i < 300; i++) begin
         r = $random(seed);
         rand_op(pm[r[3:0] % 6]);
         run_op();
      end
      ctl_write(swm_pkg::MODE_SYSTEM);
      for (int i = 0; i < 30; i++) begin
         rand_op(swm_pkg::MODE_SYSTEM);
         run_op();
      end
      ctl_write(swm_pkg::MODE_UNPRIV);
      rand_op(5'h13);
      op_kind = swm_pkg::SWM_OP_WRITE;
      cond_pass = 1'b1;
      use_saved = 1'b0;
      imm_sel = 1'b1;
      imm_value = 8'hA0;
      imm_rotate = 4'h4;
      run_op();
      for (int i = 0; i < 40; i++) begin
         r = $random(seed);
         rand_op(r[4:0]);
         run_op();
      end
      give_verdict();
   end
endmodule : status_word_transfer_and_multiply_tb
`default_nettype wire
